/* File: design/apt_defines.vh */
// register map, field positions and trigger codes of the pair trigger control
`ifndef APT_DEFINES_VH
`define APT_DEFINES_VH

// byte offsets on the register bus
`define APT_OFF_CTRL 8'h00
`define APT_OFF_PC_BASE 8'h04
`define APT_OFF_PC_LOW 8'h08
`define APT_OFF_PC_HIGH 8'h0c
`define APT_OFF_STAT 8'h10
`define APT_OFF_RES0 8'h40
`define APT_OFF_RES11 8'h6c

// converter_control fields
`define APT_CTL_ORDER 0
`define APT_CTL_EIE 1
`define APT_CTL_GSW 2
`define APT_CTL_FORM_LO 4
`define APT_CTL_FORM_HI 5

// converter_status fields
`define APT_STAT_BUSY 8

// one pair byte inside a pair control register
`define APT_PB_IRQEN 7
`define APT_PB_PEND 6
`define APT_PB_SWTRG 5

// trigger source codes
`define APT_SRC_NONE 5'h00
`define APT_SRC_SOFT 5'h01
`define APT_SRC_GLOBAL 5'h02
`define APT_SRC_SPECIAL 5'h03
`define APT_SRC_PWM1 5'h04
`define APT_SRC_PWM2 5'h05
`define APT_SRC_PWM3 5'h06
`define APT_SRC_PWM4 5'h07
`define APT_SRC_TMR1 5'h0c
`define APT_SRC_TMR2 5'h0d
`define APT_SRC_CL1 5'h0e
`define APT_SRC_CL2 5'h0f
`define APT_SRC_CL3 5'h10
`define APT_SRC_CL4 5'h11
`define APT_SRC_FLT1 5'h16
`define APT_SRC_FLT2 5'h17
`define APT_SRC_FLT3 5'h18
`define APT_SRC_FLT4 5'h19

// bus responses
`define APT_RESP_OKAY 2'h0
`define APT_RESP_SLVERR 2'h2

`endif

/* File: design/apt_fmt.v */
// result formatter: 10-bit conversion value to 16-bit word
`timescale 1ns/100ps
`default_nettype none
module apt_fmt (
   input wire [9:0] raw,
   input wire [1:0] mode,
   output reg [15:0] word
);
   always @* begin
      case (mode)
         2'h0: word = {6'h00, raw};
         2'h1: word = {{7{~raw[9]}}, raw[8:0]};
         2'h2: word = {raw, 6'h00};
         2'h3: word = {~raw[9], raw[8:0], 6'h00};
         default: word = {6'h00, raw};
      endcase
   end
endmodule
`default_nettype wire

/* File: design/apt_ctrl.v */
// pair trigger control: trigger select, pending, sequencing, results, axi4-lite registers
//
// Decided for this implementation: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "apt_defines.vh"
module apt_ctrl #(
   parameter NPAIR = 6,
   parameter NRES = 12
) (
   input wire sys_clk,
   input wire sys_rst,
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire pwm_special_trig,
   input wire [3:0] pwm_gen_trig,
   input wire [1:0] timer_period_trig,
   input wire [3:0] pwm_curlim_trig,
   input wire [3:0] pwm_fault_trig,
   output reg [5:0] sample_strobe,
   output reg conv_start,
   output reg [3:0] conv_channel,
   input wire conv_done,
   input wire [9:0] conv_data,
   output reg [5:0] pair_irq
);
   localparam [2:0] ST_IDLE = 3'b001;
   localparam [2:0] ST_FIRST = 3'b010;
   localparam [2:0] ST_SECOND = 3'b100;

   // trigger source decode; unlisted codes fall to the default
   function trig_sel;
      input [4:0] src;
      input sw;
      input gsw;
      input [14:0] hw;
      begin
         case (src)
            `APT_SRC_SOFT: trig_sel = sw;
            `APT_SRC_GLOBAL: trig_sel = gsw;
            `APT_SRC_SPECIAL: trig_sel = hw[0];
            `APT_SRC_PWM1: trig_sel = hw[1];
            `APT_SRC_PWM2: trig_sel = hw[2];
            `APT_SRC_PWM3: trig_sel = hw[3];
            `APT_SRC_PWM4: trig_sel = hw[4];
            `APT_SRC_TMR1: trig_sel = hw[5];
            `APT_SRC_TMR2: trig_sel = hw[6];
            `APT_SRC_CL1: trig_sel = hw[7];
            `APT_SRC_CL2: trig_sel = hw[8];
            `APT_SRC_CL3: trig_sel = hw[9];
            `APT_SRC_CL4: trig_sel = hw[10];
            `APT_SRC_FLT1: trig_sel = hw[11];
            `APT_SRC_FLT2: trig_sel = hw[12];
            `APT_SRC_FLT3: trig_sel = hw[13];
            `APT_SRC_FLT4: trig_sel = hw[14];
            default: trig_sel = 1'b0;
         endcase
      end
   endfunction

   // lowest numbered pending pair wins
   function [2:0] prio;
      input [5:0] req;
      integer k;
      begin
         prio = 3'h0;
         for (k = NPAIR - 1; k >= 0; k = k - 1) begin
            if (req[k]) begin
               prio = k[2:0];
            end
         end
      end
   endfunction

   function [5:0] dec6;
      input [2:0] p;
      begin
         dec6 = 6'h01 << p;
      end
   endfunction

   // pair p lives in word p/2, byte p%2
   function [7:0] pc_addr;
      input [2:0] p;
      begin
         case (p[2:1])
            2'h0: pc_addr = `APT_OFF_PC_BASE;
            2'h1: pc_addr = `APT_OFF_PC_LOW;
            default: pc_addr = `APT_OFF_PC_HIGH;
         endcase
      end
   endfunction

   reg [5:0] irqen_reg;
   reg [5:0] pend_reg;
   reg [5:0] swtrg_reg;
   reg [29:0] src_reg;
   reg order_reg;
   reg eie_reg;
   reg [1:0] form_reg;
   reg gsw_reg;
   reg [5:0] rdy_reg;
   reg [9:0] res_mem [0:NRES-1];
   reg [2:0] st_reg;
   reg [2:0] pair_reg;
   reg early_reg;

   reg aw_ok_reg;
   reg [7:0] awaddr_reg;
   reg w_ok_reg;
   reg [31:0] wdata_reg;
   reg [3:0] wstrb_reg;

   wire [14:0] hw_trig;
   wire [5:0] hit;
   wire wr_en;
   wire conv_ok_first;
   wire conv_ok_second;
   wire [5:0] irq_fire;
   wire [5:0] done_vec;
   wire [15:0] fmt_word;
   wire [3:0] rd_idx;
   reg [31:0] rd_data;
   reg rd_err;
   integer i;
   integer j;

   assign hw_trig = {pwm_fault_trig, pwm_curlim_trig, timer_period_trig,
                     pwm_gen_trig, pwm_special_trig};

   genvar g;
   generate
      for (g = 0; g < NPAIR; g = g + 1) begin : gen_hit
         assign hit[g] = trig_sel(src_reg[5*g+4:5*g], swtrg_reg[g], gsw_reg, hw_trig);
      end
   endgenerate

   // ---------------- axi4-lite write side ----------------
   assign s_axi_awready = !aw_ok_reg && !s_axi_bvalid;
   assign s_axi_wready = !w_ok_reg && !s_axi_bvalid;
   assign wr_en = aw_ok_reg && w_ok_reg && !s_axi_bvalid;

   always @(posedge sys_clk) begin
      if (sys_rst) begin
         aw_ok_reg <= 1'b0;
         awaddr_reg <= 8'h00;
         w_ok_reg <= 1'b0;
         wdata_reg <= 32'h00000000;
         wstrb_reg <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `APT_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_ok_reg <= 1'b1;
            awaddr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_ok_reg <= 1'b1;
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
         end
         if (wr_en) begin
            aw_ok_reg <= 1'b0;
            w_ok_reg <= 1'b0;
            s_axi_bvalid <= 1'b1;
            case ({awaddr_reg[7:2], 2'b00})
               `APT_OFF_CTRL, `APT_OFF_PC_BASE, `APT_OFF_PC_LOW,
               `APT_OFF_PC_HIGH, `APT_OFF_STAT: s_axi_bresp <= `APT_RESP_OKAY;
               default: s_axi_bresp <= `APT_RESP_SLVERR;
            endcase
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // ---------------- control register ----------------
   // global trigger is a one-cycle pulse; it never reads back as 1
   always @(posedge sys_clk) begin
      if (sys_rst) begin
         order_reg <= 1'b0;
         eie_reg <= 1'b0;
         form_reg <= 2'h0;
         gsw_reg <= 1'b0;
      end else begin
         gsw_reg <= 1'b0;
         if (wr_en && {awaddr_reg[7:2], 2'b00} == `APT_OFF_CTRL && wstrb_reg[0]) begin
            order_reg <= wdata_reg[`APT_CTL_ORDER];
            eie_reg <= wdata_reg[`APT_CTL_EIE];
            form_reg <= wdata_reg[`APT_CTL_FORM_HI:`APT_CTL_FORM_LO];
            gsw_reg <= wdata_reg[`APT_CTL_GSW];
         end
      end
   end

   // ---------------- pair control fields ----------------
   always @(posedge sys_clk) begin
      if (sys_rst) begin
         irqen_reg <= 6'h00;
         pend_reg <= 6'h00;
         swtrg_reg <= 6'h00;
         src_reg <= 30'h00000000;
         sample_strobe <= 6'h00;
      end else begin
         sample_strobe <= hit;
         for (i = 0; i < NPAIR; i = i + 1) begin
            // completion clears, a new trigger in the same cycle wins
            if (done_vec[i]) begin
               pend_reg[i] <= 1'b0;
            end
            if (hit[i]) begin
               pend_reg[i] <= 1'b1;
               swtrg_reg[i] <= 1'b0;
            end
            // pending is hardware-owned; writes leave it alone
            if (wr_en && {awaddr_reg[7:2], 2'b00} == pc_addr(i[2:0]) && wstrb_reg[i%2]) begin
               if (i % 2 == 1) begin
                  irqen_reg[i] <= wdata_reg[8+`APT_PB_IRQEN];
                  swtrg_reg[i] <= wdata_reg[8+`APT_PB_SWTRG];
                  src_reg[5*i+:5] <= wdata_reg[12:8];
               end else begin
                  irqen_reg[i] <= wdata_reg[`APT_PB_IRQEN];
                  swtrg_reg[i] <= wdata_reg[`APT_PB_SWTRG];
                  src_reg[5*i+:5] <= wdata_reg[4:0];
               end
            end
         end
      end
   end

   // ---------------- conversion sequencer ----------------
   assign conv_ok_first = st_reg == ST_FIRST && conv_done;
   assign conv_ok_second = st_reg == ST_SECOND && conv_done;
   assign done_vec = conv_ok_second ? dec6(pair_reg) : 6'h00;
   assign irq_fire = ((conv_ok_first && early_reg) || (conv_ok_second && !early_reg)) ?
                     (dec6(pair_reg) & irqen_reg) : 6'h00;

   always @(posedge sys_clk) begin
      if (sys_rst) begin
         st_reg <= ST_IDLE;
         pair_reg <= 3'h0;
         early_reg <= 1'b0;
         conv_start <= 1'b0;
         conv_channel <= 4'h0;
         pair_irq <= 6'h00;
      end else begin
         conv_start <= 1'b0;
         pair_irq <= irq_fire;
         case (st_reg)
            ST_IDLE: begin
               // requests made while busy wait here in pending
               if (|pend_reg) begin
                  pair_reg <= prio(pend_reg);
                  conv_channel <= {prio(pend_reg), order_reg};
                  early_reg <= eie_reg;
                  conv_start <= 1'b1;
                  st_reg <= ST_FIRST;
               end
            end
            ST_FIRST: begin
               if (conv_done) begin
                  conv_channel <= {conv_channel[3:1], ~conv_channel[0]};
                  conv_start <= 1'b1;
                  st_reg <= ST_SECOND;
               end
            end
            ST_SECOND: begin
               if (conv_done) begin
                  st_reg <= ST_IDLE;
               end
            end
            default: st_reg <= ST_IDLE;
         endcase
      end
   end

   // fixed slot per input, no queue; an unread value is simply replaced
   always @(posedge sys_clk) begin
      if (conv_ok_first || conv_ok_second) begin
         if (conv_channel < NRES) begin
            res_mem[conv_channel] <= conv_data;
         end
      end
   end

   // ready flags: set beats a same-cycle software clear
   always @(posedge sys_clk) begin
      if (sys_rst) begin
         rdy_reg <= 6'h00;
      end else begin
         if (wr_en && {awaddr_reg[7:2], 2'b00} == `APT_OFF_STAT && wstrb_reg[0]) begin
            rdy_reg <= (rdy_reg & ~wdata_reg[5:0]) | irq_fire;
         end else begin
            rdy_reg <= rdy_reg | irq_fire;
         end
      end
   end

   // ---------------- axi4-lite read side ----------------
   assign s_axi_arready = !s_axi_rvalid;
   // result window sits on a 64-byte boundary, so bits 5:2 are the slot
   assign rd_idx = s_axi_araddr[5:2];

   apt_fmt u_fmt (
      .raw(res_mem[rd_idx < NRES ? rd_idx : 4'h0]),
      .mode(form_reg),
      .word(fmt_word)
   );

   always @* begin
      rd_data = 32'h00000000;
      rd_err = 1'b0;
      case ({s_axi_araddr[7:2], 2'b00})
         `APT_OFF_CTRL: begin
            rd_data[`APT_CTL_ORDER] = order_reg;
            rd_data[`APT_CTL_EIE] = eie_reg;
            rd_data[`APT_CTL_FORM_HI:`APT_CTL_FORM_LO] = form_reg;
         end
         `APT_OFF_PC_BASE, `APT_OFF_PC_LOW, `APT_OFF_PC_HIGH: begin
            for (j = 0; j < NPAIR; j = j + 1) begin
               if ({s_axi_araddr[7:2], 2'b00} == pc_addr(j[2:0])) begin
                  rd_data[8*(j%2)+:8] = {irqen_reg[j], pend_reg[j], swtrg_reg[j],
                                         src_reg[5*j+:5]};
               end
            end
         end
         `APT_OFF_STAT: begin
            rd_data[5:0] = rdy_reg;
            rd_data[`APT_STAT_BUSY] = st_reg != ST_IDLE;
         end
         default: begin
            if (s_axi_araddr >= `APT_OFF_RES0 && s_axi_araddr <= `APT_OFF_RES11) begin
               rd_data[15:0] = fmt_word;
            end else begin
               rd_err = 1'b1;
            end
         end
      endcase
   end

   always @(posedge sys_clk) begin
      if (sys_rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `APT_RESP_OKAY;
      end else begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_data;
            s_axi_rresp <= rd_err ? `APT_RESP_SLVERR : `APT_RESP_OKAY;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

/* File: dv/apt_ctrl_assertions.sv */
// checker: bus hold, pairing and interrupt timing on the control block ports
`timescale 1ns/100ps
`default_nettype none
module apt_ctrl_chk (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic conv_start,
   input wire logic [3:0] conv_channel,
   input wire logic conv_done,
   input wire logic [5:0] pair_irq
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   // second_reg high between the first and second start of a pair
   logic second_reg;
   logic [3:0] first_reg;
   always @(posedge sys_clk) begin
      if (sys_rst) begin
         second_reg <= 1'b0;
         first_reg <= 4'h0;
      end else if (conv_start) begin
         second_reg <= !second_reg;
         first_reg <= conv_channel;
      end
   end
   sequence s_first_done;
      conv_done && second_reg;
   endsequence
   property p_first_done_start;
      s_first_done |=> conv_start;
   endproperty
   a_first_done_start: assert property (p_first_done_start) else $error("no second start");
   property p_chan_pair;
      conv_start && second_reg |-> conv_channel == (first_reg ^ 4'h1);
   endproperty
   a_chan_pair: assert property (p_chan_pair) else $error("second channel not partner");
   property p_chan_stable;
      !conv_start |-> $stable(conv_channel);
   endproperty
   a_chan_stable: assert property (p_chan_stable) else $error("channel moved");
   property p_start_pulse;
      conv_start |=> !conv_start;
   endproperty
   a_start_pulse: assert property (p_start_pulse) else $error("start too long");
   property p_irq_after_done;
      |pair_irq |-> $past(conv_done);
   endproperty
   a_irq_after_done: assert property (p_irq_after_done) else $error("irq without done");
   property p_irq_pulse;
      |pair_irq |=> (pair_irq & $past(pair_irq)) == 6'h0;
   endproperty
   a_irq_pulse: assert property (p_irq_pulse) else $error("irq held");
   property p_rvalid_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_rvalid_hold: assert property (p_rvalid_hold) else $error("read data dropped");
   property p_rdata_upper;
      s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0;
   endproperty
   a_rdata_upper: assert property (p_rdata_upper) else $error("upper half set");
endmodule
bind apt_ctrl apt_ctrl_chk u_apt_ctrl_chk (.sys_clk(sys_clk), .sys_rst(sys_rst),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
   .conv_start(conv_start), .conv_channel(conv_channel), .conv_done(conv_done),
   .pair_irq(pair_irq));
`default_nettype wire

/* File: dv/apt_sar_model.sv */
// converter engine model: answers each start after a set latency
`timescale 1ns/100ps
`default_nettype none
module apt_sar_model (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic conv_start,
   input wire logic [3:0] conv_channel,
   input wire logic [9:0] data_base,
   input wire logic [7:0] latency,
   output logic conv_done,
   output logic [9:0] conv_data
);
   logic [7:0] cnt_reg;
   logic busy_reg;
   always @(posedge sys_clk) begin
      conv_done <= 1'b0;
      // junk between results so a stale value is never trusted
      conv_data <= conv_data + 10'h155;
      if (sys_rst) begin
         busy_reg <= 1'b0;
         cnt_reg <= 8'h0;
         conv_data <= 10'h0;
      end else if (conv_start) begin
         busy_reg <= 1'b1;
         cnt_reg <= latency;
      end else if (busy_reg && cnt_reg == 8'h0) begin
         busy_reg <= 1'b0;
         conv_done <= 1'b1;
         conv_data <= data_base + {6'h0, conv_channel};
      end else if (busy_reg) begin
         cnt_reg <= cnt_reg - 8'h1;
      end
   end
endmodule
`default_nettype wire

/* File: dv/tb_apt_ctrl.sv */
// testbench: trigger codes, soft and global triggers, priority, results
`timescale 1ns/100ps
`default_nettype none
module tb_apt_ctrl;
   logic sys_clk, sys_rst, awvalid, wvalid, bready, arvalid, rready;
   logic [7:0] awaddr, araddr, lat;
   logic [31:0] wdata;
   logic [3:0] wstrb;
   wire awready, wready, bvalid, arready, rvalid, conv_start, conv_done;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   wire [5:0] sample_strobe, pair_irq;
   wire [3:0] conv_channel;
   wire [9:0] conv_data;
   logic [14:0] trig;
   logic [9:0] base;
   logic [5:0] irq_seen;
   logic [3:0] ch_log [$];
   int ndone, irq_nd, errors, tests_run;
   apt_ctrl u_apt_ctrl (.sys_clk(sys_clk), .sys_rst(sys_rst), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .pwm_special_trig(trig[0]), .pwm_gen_trig(trig[4:1]),
      .timer_period_trig(trig[6:5]), .pwm_curlim_trig(trig[10:7]), .pwm_fault_trig(trig[14:11]),
      .sample_strobe(sample_strobe), .conv_start(conv_start), .conv_channel(conv_channel),
      .conv_done(conv_done), .conv_data(conv_data), .pair_irq(pair_irq));
   apt_sar_model u_apt_sar_model (.sys_clk(sys_clk), .sys_rst(sys_rst), .conv_start(conv_start),
      .conv_channel(conv_channel), .data_base(base), .latency(lat), .conv_done(conv_done),
      .conv_data(conv_data));
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   // sample 2 ns after each edge, where outputs have settled
   always @(posedge sys_clk) begin
      #2;
      if (conv_start) ch_log.push_back(conv_channel);
      if (conv_done) ndone++;
      if (pair_irq != 6'h0) irq_nd = ndone;
      irq_seen = irq_seen | pair_irq;
   end
   task automatic tally_and_finish;
      $display("tests_run=%0d errors=%0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic to_fail;
      errors++;
      $display("BAD wait expected answer seen none");
      tally_and_finish();
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         errors++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   // handshakes judged from values settled before the edge that takes them
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic aw, w, b;
      int n;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      b = 1'b0;
      for (n = 0; n < 40 && !b; n++) begin
         #2;
         aw = awvalid && awready;
         w = wvalid && wready;
         b = bvalid;
         if (b) chk("bresp", {30'h0, er}, {30'h0, bresp});
         @(posedge sys_clk);
         if (aw) awvalid <= 1'b0;
         if (w) wvalid <= 1'b0;
      end
      bready <= 1'b0;
      // release gets its own edge, so a following call never reassigns it in one step
      @(posedge sys_clk);
      if (!b) to_fail();
   endtask
   task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      logic ar, r;
      int n;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      r = 1'b0;
      for (n = 0; n < 40 && !r; n++) begin
         #2;
         ar = arvalid && arready;
         r = rvalid;
         if (r) chk("rdata", ed, rdata);
         if (r) chk("rresp", {30'h0, er}, {30'h0, rresp});
         @(posedge sys_clk);
         if (ar) arvalid <= 1'b0;
      end
      rready <= 1'b0;
      @(posedge sys_clk);
      if (!r) to_fail();
   endtask
   task automatic pulse(input logic [14:0] t, input logic [5:0] m, input logic [5:0] e);
      trig <= t;
      @(posedge sys_clk);
      trig <= 15'h0;
      #2;
      chk("strobe", {26'h0, e}, {26'h0, sample_strobe & m});
      @(posedge sys_clk);
   endtask
   task automatic wait_done(input int t);
      int n;
      for (n = 0; n < 600 && ndone < t; n++) @(posedge sys_clk);
      if (ndone < t) to_fail();
      repeat (3) @(posedge sys_clk);
   endtask
   task automatic t_reset;
      int k;
      for (k = 0; k < 5; k++) axi_rd(8'(4 * k), 32'h0, 2'h0);
      axi_rd(8'h20, 32'h0, 2'h2);
      axi_wr(8'h20, 32'hffff, 2'h2);
      $display("test reset done");
   endtask
   task automatic t_hw;
      logic [4:0] cd [15] = '{5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h0c, 5'h0d, 5'h0e, 5'h0f,
         5'h10, 5'h11, 5'h16, 5'h17, 5'h18, 5'h19};
      int i, p, n0;
      logic [15:0] v;
      for (i = 0; i < 15; i++) begin
         p = i % 6;
         base <= 10'(i * 41);
         v = {8'h0, 3'h4, cd[i]} << (8 * (p % 2));
         axi_wr(8'h04 + 8'(4 * (p / 2)), {16'h0, v}, 2'h0);
         n0 = ndone;
         ch_log.delete();
         pulse(15'(1 << i), 6'h3f, 6'(1 << p));
         wait_done(n0 + 2);
         chk("first", {28'h0, 4'(2 * p)}, {28'h0, ch_log[0]});
         axi_rd(8'h40 + 8'(8 * p), {22'h0, base + 10'(2 * p)}, 2'h0);
         axi_rd(8'h44 + 8'(8 * p), {22'h0, base + 10'(2 * p + 1)}, 2'h0);
         axi_rd(8'h04 + 8'(4 * (p / 2)), {16'h0, v}, 2'h0);
      end
      $display("test hw codes done");
   endtask
   task automatic t_unl;
      int c, n0;
      // pairs left armed by the code sweep would answer the all-ones pulse
      axi_wr(8'h08, 32'h0, 2'h0);
      axi_wr(8'h0c, 32'h0, 2'h0);
      n0 = ndone;
      for (c = 0; c < 32; c++) begin
         if (!(c inside {[1:7], [12:17], [22:25]})) begin
            axi_wr(8'h04, {24'h0, 3'h4, 5'(c)}, 2'h0);
            pulse(15'h7fff, 6'h3f, 6'h0);
         end
      end
      repeat (5) @(posedge sys_clk);
      chk("dones", n0, ndone);
      $display("test unlisted done");
   endtask
   task automatic t_soft;
      logic [15:0] fx [3] = '{16'h000b, 16'h82c0, 16'h02c0};
      int n0, k;
      axi_wr(8'h10, 32'h3f, 2'h0);
      n0 = ndone;
      irq_seen = 6'h0;
      base <= 10'h200;
      axi_wr(8'h0c, 32'h21a1, 2'h0);
      wait_done(n0 + 4);
      chk("irq", 32'h10, {26'h0, irq_seen});
      axi_rd(8'h0c, 32'h0181, 2'h0);
      axi_rd(8'h10, 32'h10, 2'h0);
      axi_rd(8'h6c, 32'h20b, 2'h0);
      axi_wr(8'h6c, 32'h0, 2'h2);
      axi_rd(8'h6c, 32'h20b, 2'h0);
      // signed, fraction and signed fraction views of the same slot
      for (k = 1; k < 4; k++) begin
         axi_wr(8'h00, 32'(16 * k), 2'h0);
         axi_rd(8'h6c, {16'h0, fx[k - 1]}, 2'h0);
      end
      $display("test soft done");
   endtask
   task automatic t_glob;
      logic [3:0] ex [6] = '{4'h5, 4'h4, 4'h7, 4'h6, 4'hb, 4'ha};
      int n0, k;
      axi_wr(8'h10, 32'h3f, 2'h0);
      axi_wr(8'h04, 32'h8100, 2'h0);
      axi_wr(8'h08, 32'h8282, 2'h0);
      axi_wr(8'h0c, 32'h8300, 2'h0);
      n0 = ndone;
      irq_seen = 6'h0;
      ch_log.delete();
      lat <= 8'h6;
      axi_wr(8'h00, 32'h5, 2'h0);
      pulse(15'h1, 6'h20, 6'h20);
      wait_done(n0 + 6);
      for (k = 0; k < 6; k++) chk("order", {28'h0, ex[k]}, {28'h0, ch_log[k]});
      chk("irq", 32'h2c, {26'h0, irq_seen});
      axi_rd(8'h10, 32'h2c, 2'h0);
      axi_wr(8'h10, 32'h2c, 2'h0);
      axi_rd(8'h10, 32'h0, 2'h0);
      $display("test global done");
   endtask
   task automatic t_early;
      int n0;
      lat <= 8'h1e;
      axi_wr(8'h00, 32'h2, 2'h0);
      n0 = ndone;
      ch_log.delete();
      axi_wr(8'h04, 32'ha1, 2'h0);
      repeat (4) @(posedge sys_clk);
      axi_rd(8'h04, 32'hc1, 2'h0);
      wait_done(n0 + 2);
      chk("early", n0 + 1, irq_nd);
      chk("first", 32'h0, {28'h0, ch_log[0]});
      $display("test early done");
   endtask
   initial begin
      sys_rst = 1'b1;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
      awaddr = 8'h0;
      araddr = 8'h0;
      wdata = 32'h0;
      wstrb = 4'h3;
      trig = 15'h0;
      base = 10'h0;
      lat = 8'h4;
      irq_seen = 6'h0;
      repeat (10) @(posedge sys_clk);
      sys_rst <= 1'b0;
      @(posedge sys_clk);
      t_reset();
      t_hw();
      t_unl();
      t_soft();
      t_glob();
      t_early();
      tally_and_finish();
   end
endmodule
`default_nettype wire
